/* File: verilog/pcm_port_params.svh */
/*
  Register offsets, field positions, reset values and counts of the
  PCM highway port. Included by the package users; holds defines only.
*/
`ifndef PCM_PORT_PARAMS_SVH
`define PCM_PORT_PARAMS_SVH

// byte addresses on the register bus
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_SLOT_BASE   8'h10
`define REG_TXDATA_BASE 8'h20
`define REG_RXDATA_BASE 8'h30

// control register fields
`define CTRL_TXSH_LSB   0
`define CTRL_RXSH_LSB   4
`define CTRL_PD_LSB     8
`define CTRL_RESET      32'h0000_0F00

// slot register fields
`define SLOT_TX_LSB     0
`define SLOT_TXEN_BIT   7
`define SLOT_RX_LSB     8
`define SLOT_RXEN_BIT   15

// status register fields
`define STAT_RATE_LSB   0
`define STAT_NORM_BIT   2
`define STAT_OVR_BIT    3

// frame shift limit and bits-per-frame thresholds of the four rates
`define SHIFT_MAX       3'h7
`define BITS_LIM_1M5    10'h0C8
`define BITS_LIM_2M     10'h12C
`define BITS_LIM_4M     10'h258
`define SLOTS_1M5       8'h18
`define SLOTS_2M        8'h20
`define SLOTS_4M        8'h40
`define SLOTS_8M        8'h80

`endif

/* File: verilog/pcm_port_pkg.sv */
/*
  Types shared by the PCM highway port, its assertions and its testbench.
  Assumes the params header is included by the users.
*/
package pcm_port_pkg;

  typedef enum logic [1:0] {
    MODE_RESET  = 2'b01,
    MODE_NORMAL = 2'b10
  } mode_t;

  typedef struct packed {
    logic [1:0] chan;
    logic [7:0] data;
  } rx_word_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] slot;
    logic [2:0] bit_idx;
  } slot_pos_t;

endpackage

/* File: verilog/pcm_fifo2.sv */
/*
  Small shift-style buffer with valid/ready on both sides.
  Head entry and its valid bit are plain flip-flops, so the drain side
  sees registered outputs. Same clock as the writer and reader.
*/
`timescale 1ns/10ps
module pcm_fifo2 #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0] full_q;
  logic             pop;
  logic             push;

  // ready only while the top entry is free: back-pressure to the source
  assign in_ready  = ~full_q[DEPTH-1];
  assign push      = in_valid & in_ready;
  assign pop       = full_q[0] & out_ready;
  assign out_data  = mem_q[0];
  assign out_valid = full_q[0];

  // shift down on pop, write into the first free slot after the shift
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      full_q <= '0;
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        logic occ;
        occ = (i + 1 < DEPTH) ? full_q[i + 1] : 1'b0;
        if (pop) begin
          full_q[i] <= occ | (push & ~occ & (i == 0 || full_q[i]));
          if (i + 1 < DEPTH && occ) mem_q[i] <= mem_q[i + 1];
          else if (push && (i == 0 || full_q[i])) mem_q[i] <= in_data;
        end else if (push && !full_q[i] && (i == 0 || full_q[i - 1])) begin
          full_q[i] <= 1'b1;
          mem_q[i]  <= in_data;
        end
      end
    end
  end
endmodule // pcm_fifo2

/* File: verilog/pcm_highway_port.sv */
/*
  One PCM highway port of a four-channel voice codec: mode pins, frame
  pulse, bit clock rate detection, transmit/receive slot timing, data
  tristate and the open-drain slot strobe, plus an Avalon-MM register
  slave. Assumes the bit clock, frame pulse, mode pins and receive data
  all come from outside the mclk domain and are much slower than mclk.
*/
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
// Functional notes
// - mode pins: 00 holds reset, high pin set with low pin clear runs
// - one 8 kHz frame pulse starts both receive and transmit frames
// - frame start delayed 0..7 bit periods, separately per direction
// - bits per frame detected, giving one of four rates and slot count
// - the master clock pin is the bit clock for both directions; here the bit clock is the separate pcm_bit_clk input, not mclk
// - open-drain strobe pulled low exactly during active transmit slots
// - transmit output high impedance except in assigned slots
// - byte shifted out MSB first, changing on rising bit clock edges
// - receive input ignored outside assigned receive slots
// - received bits sampled on falling bit clock edges
// - in reset, output tristated and no slots assigned
// - powered-down channel releases its transmit slot
`timescale 1ns/10ps
`include "pcm_port_params.svh"
module pcm_highway_port
  import pcm_port_pkg::*;
#(
  parameter int NCH = 4
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        mode_select_low,
  input  wire logic        mode_select_high,
  input  wire logic        frame_pulse,
  input  wire logic        pcm_bit_clk,
  input  wire logic        pcm_rx_in_a,
  output logic             pcm_tx_out_a_o,
  output logic             pcm_tx_out_a_oe,
  output logic             tx_slot_strobe_a_o,
  output logic             tx_slot_strobe_a_oe,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output rx_word_t         rx_word,
  output logic             rx_word_valid,
  input  wire logic        rx_word_ready
);

  // two-flop synchronisers; stage 1 read only by stage 2
  logic [1:0] bclk_s1_q, bclk_s2_q;
  logic       bclk_s3_q;
  logic [4:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_s1_q  <= '0;
      pin_s2_q  <= '0;
      bclk_s1_q <= '0;
      bclk_s2_q <= '0;
      bclk_s3_q <= 1'b0;
    end else begin
      pin_s1_q  <= {mode_select_high, mode_select_low, frame_pulse,
                    pcm_rx_in_a, 1'b0};
      pin_s2_q  <= pin_s1_q;
      bclk_s1_q <= {pcm_bit_clk, 1'b0};
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q[1];
    end
  end

  wire m_high  = pin_s2_q[4];
  wire m_low   = pin_s2_q[3];
  wire fp_s    = pin_s2_q[2];
  wire rxd_s   = pin_s2_q[1];
  wire b_rise  = bclk_s2_q[1] & ~bclk_s3_q;
  wire b_fall  = ~bclk_s2_q[1] & bclk_s3_q;

  // mode decode; forbidden codes are treated as reset for safety
  mode_t mode_q;
  wire   run_pins = m_high & ~m_low;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) mode_q <= MODE_RESET;
    else begin
      case (mode_q)
        MODE_RESET:  if (run_pins) mode_q <= MODE_NORMAL;
        MODE_NORMAL: if (!run_pins) mode_q <= MODE_RESET;
        default:     mode_q <= MODE_RESET;
      endcase
    end
  end
  wire in_reset = (mode_q != MODE_NORMAL);

  // position of a frame bit counter within a shifted frame
  function automatic slot_pos_t pos_of(input logic [9:0] cnt,
                                       input logic [2:0] sh,
                                       input logic [7:0] nslots);
    logic [9:0] p;
    p = cnt - {7'h00, sh};
    pos_of.valid   = (cnt >= {7'h00, sh}) && ({1'b0, p[9:3]} < nslots);
    pos_of.slot    = p[9:3];
    pos_of.bit_idx = p[2:0];
  endfunction

  // frame pulse sampled on falling bit clock edges, rise detected
  logic       fp_last_q, frame_arm_q;
  logic [9:0] cnt_q, frame_bits_q;
  logic [1:0] rate_q;
  wire  [9:0] cnt_d = frame_arm_q ? 10'h000 :
                      (&cnt_q ? cnt_q : cnt_q + 10'h001);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fp_last_q    <= 1'b1;
      frame_arm_q  <= 1'b0;
      cnt_q        <= 10'h3FF;
      frame_bits_q <= 10'h000;
    end else begin
      if (b_fall) begin
        fp_last_q <= fp_s;
        if (fp_s && !fp_last_q) frame_arm_q <= 1'b1;
      end
      if (b_rise) begin
        cnt_q       <= cnt_d;
        frame_arm_q <= 1'b0;
        if (frame_arm_q) frame_bits_q <= cnt_q + 10'h001;
      end
    end
  end

  // rate class from bits per frame; slot count follows it
  wire [1:0] rate_d = (frame_bits_q <= `BITS_LIM_1M5) ? 2'h0 :
                      (frame_bits_q <= `BITS_LIM_2M)  ? 2'h1 :
                      (frame_bits_q <= `BITS_LIM_4M)  ? 2'h2 : 2'h3;
  wire [7:0] nslots = (rate_q == 2'h0) ? `SLOTS_1M5 :
                      (rate_q == 2'h1) ? `SLOTS_2M  :
                      (rate_q == 2'h2) ? `SLOTS_4M  : `SLOTS_8M;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) rate_q <= 2'h0;
    else       rate_q <= rate_d;
  end

  // software registers
  logic [31:0] ctrl_q;
  logic [15:0] slot_q   [NCH];
  logic [7:0]  txdata_q [NCH];
  logic [7:0]  rxdata_q [NCH];
  logic        ovr_q;
  wire  [2:0]  tx_sh  = ctrl_q[`CTRL_TXSH_LSB +: 3];
  wire  [2:0]  rx_sh  = ctrl_q[`CTRL_RXSH_LSB +: 3];
  wire  [3:0]  pd     = ctrl_q[`CTRL_PD_LSB +: 4];

  // slot positions for the next transmit bit and the current receive bit
  slot_pos_t tx_pos, rx_pos;
  assign tx_pos = pos_of(cnt_d, tx_sh, nslots);
  assign rx_pos = pos_of(cnt_q, rx_sh, nslots);

  // channel matching; lowest channel wins if software overlaps slots
  logic [NCH-1:0] tx_hit, rx_hit;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      tx_hit[c] = !in_reset && tx_pos.valid && !pd[c] &&
                  slot_q[c][`SLOT_TXEN_BIT] &&
                  slot_q[c][`SLOT_TX_LSB +: 7] == tx_pos.slot;
      rx_hit[c] = !in_reset && rx_pos.valid &&
                  slot_q[c][`SLOT_RXEN_BIT] &&
                  slot_q[c][`SLOT_RX_LSB +: 7] == rx_pos.slot;
    end
  end
  logic [1:0] tx_ch, rx_ch;
  always_comb begin
    tx_ch = 2'h0;
    rx_ch = 2'h0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (tx_hit[c]) tx_ch = c[1:0];
      if (rx_hit[c]) rx_ch = c[1:0];
    end
  end
  wire tx_any = |tx_hit;
  wire rx_any = |rx_hit;

  // transmit pins change on rising bit clock edges; mode reset drops both drives at once
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pcm_tx_out_a_o      <= 1'b0;
      pcm_tx_out_a_oe     <= 1'b0;
      tx_slot_strobe_a_oe <= 1'b0;
    end else if (in_reset) begin
      pcm_tx_out_a_oe     <= 1'b0;
      tx_slot_strobe_a_oe <= 1'b0;
    end else if (b_rise) begin
      pcm_tx_out_a_o      <= txdata_q[tx_ch][3'h7 - tx_pos.bit_idx];
      pcm_tx_out_a_oe     <= tx_any;
      tx_slot_strobe_a_oe <= tx_any;
    end
  end
  // open-drain strobe only ever pulls low
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) tx_slot_strobe_a_o <= 1'b0;
    else       tx_slot_strobe_a_o <= 1'b0;
  end

  // receive shift register, sampled on falling bit clock edges
  logic [6:0] rx_sh_q;
  logic       push_q;
  rx_word_t   push_word_q;
  logic       fifo_in_ready;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_sh_q     <= 7'h00;
      push_q      <= 1'b0;
      push_word_q <= '0;
    end else begin
      push_q <= 1'b0;
      if (b_fall && rx_any) begin
        rx_sh_q <= {rx_sh_q[5:0], rxd_s};
        if (rx_pos.bit_idx == 3'h7) begin
          push_q           <= 1'b1;
          push_word_q.chan <= rx_ch;
          push_word_q.data <= {rx_sh_q, rxd_s};
        end
      end
    end
  end

  // a full buffer drops the byte and flags it; the link cannot stall
  pcm_fifo2 #(
    .WIDTH ($bits(rx_word_t)),
    .DEPTH (2)
  ) u_rx_buf (
    .mclk      (mclk),
    .reset     (reset),
    .in_data   (push_word_q),
    .in_valid  (push_q),
    .in_ready  (fifo_in_ready),
    .out_data  (rx_word),
    .out_valid (rx_word_valid),
    .out_ready (rx_word_ready)
  );

  // bus decode: one word per register, waitrequest drops for one cycle
  logic        wait_q;
  wire         req      = (avs_read | avs_write) & wait_q;
  wire         accept   = (avs_read | avs_write) & ~wait_q;
  wire         do_write = accept & avs_write;
  wire [1:0]   idx      = avs_address[3:2];
  wire         hit_ctrl = (avs_address == `REG_CTRL);
  wire         hit_stat = (avs_address == `REG_STATUS);
  wire         hit_slot = (avs_address[7:4] == `REG_SLOT_BASE >> 4);
  wire         hit_txd  = (avs_address[7:4] == `REG_TXDATA_BASE >> 4);
  wire         hit_rxd  = (avs_address[7:4] == `REG_RXDATA_BASE >> 4);
  wire [31:0]  status   = {28'h0000000, ovr_q, ~in_reset, rate_q};
  wire [31:0]  rd_mux   =
      hit_ctrl ? ctrl_q :
      hit_stat ? status :
      hit_slot ? {16'h0000, slot_q[idx]} :
      hit_txd  ? {24'h000000, txdata_q[idx]} :
      hit_rxd  ? {24'h000000, rxdata_q[idx]} : 32'h0000_0000;

  // byte-enable merge used by the control and slot registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
  endfunction

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wait_q       <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      wait_q <= ~req;
      if (req) avs_readdata <= rd_mux;
    end
  end
  assign avs_waitrequest = wait_q;

  // register writes; slots forced clear while the mode pins hold reset
  wire ovr_set = push_q & ~fifo_in_ready;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `CTRL_RESET;
      ovr_q  <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        slot_q[c]   <= 16'h0000;
        txdata_q[c] <= 8'h00;
        rxdata_q[c] <= 8'h00;
      end
    end else begin
      if (do_write && hit_ctrl)
        ctrl_q <= merge(ctrl_q, avs_writedata, avs_byteenable) &
                  32'h0000_0F77;
      // set wins over the write-one clear
      if (ovr_set) ovr_q <= 1'b1;
      else if (do_write && hit_stat && avs_byteenable[0] &&
               avs_writedata[`STAT_OVR_BIT]) ovr_q <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        if (in_reset) slot_q[c] <= 16'h0000;
        else if (do_write && hit_slot && idx == c[1:0])
          slot_q[c] <= 16'(merge({16'h0000, slot_q[c]}, avs_writedata,
                                 avs_byteenable));
        if (do_write && hit_txd && idx == c[1:0] && avs_byteenable[0])
          txdata_q[c] <= avs_writedata[7:0];
        if (push_q && push_word_q.chan == c[1:0])
          rxdata_q[c] <= push_word_q.data;
      end
    end
  end

endmodule // pcm_highway_port

/* File: tb/pcm_highway_port_asserts.sv */
/* Concurrent checks on the PCM port pins and its register slave.
   Assumes a bind into pcm_highway_port; sees only its ports. */
`timescale 1ns/10ps
module pcm_highway_port_asserts
  import pcm_port_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        mode_select_low,
  input wire logic        mode_select_high,
  input wire logic        pcm_bit_clk,
  input wire logic        pcm_tx_out_a_o,
  input wire logic        pcm_tx_out_a_oe,
  input wire logic        tx_slot_strobe_a_o,
  input wire logic        tx_slot_strobe_a_oe,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire rx_word_t    rx_word,
  input wire logic        rx_word_valid,
  input wire logic        rx_word_ready
);
  logic [15:0] oe_len_q;
  logic [15:0] oe_len_d;

  // cycles the data drive has stood so far
  assign oe_len_d = pcm_tx_out_a_oe ? oe_len_q + 16'h1 : 16'h0;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) oe_len_q <= 16'h0;
    else oe_len_q <= oe_len_d;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // strobe opens and closes with the data drive
  strobe_follow_a: assert property (
    tx_slot_strobe_a_oe == pcm_tx_out_a_oe)
    else $error("strobe and data drive disagree");
  strobe_level_a: assert property (tx_slot_strobe_a_o == 1'b0)
    else $error("strobe value not low");
  // pin reset must silence the port within the synchroniser delay
  mode_quiet_a: assert property (
    (!mode_select_high || mode_select_low) [*6] |-> !pcm_tx_out_a_oe)
    else $error("drive outside normal mode");
  slot_len_a: assert property (
    $fell(pcm_tx_out_a_oe) |-> oe_len_q >= 16'h13C)
    else $error("drive shorter than eight bits");
  // 40 cycles per bit: changes land while the bit clock is still high
  tx_edge_a: assert property (
    $rose(pcm_tx_out_a_oe) || (pcm_tx_out_a_oe && $changed(pcm_tx_out_a_o))
    |-> pcm_bit_clk)
    else $error("data changed away from rising bit clock");
  rx_edge_a: assert property ($rose(rx_word_valid) |-> !pcm_bit_clk)
    else $error("word not taken at falling bit clock");
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than a cycle");
  read_hold_a: assert property (
    !(avs_read || avs_write) |=> $stable(avs_readdata))
    else $error("read data moved without a request");
  word_hold_a: assert property (
    rx_word_valid && !rx_word_ready |=> rx_word_valid && $stable(rx_word))
    else $error("stalled word lost or changed");
endmodule // pcm_highway_port_asserts

/* File: tb/pcm_backplane.sv */
/* Backplane model: free bit clock, frame pulse, receive slot data and
   capture of the transmit slot. Assumes resolved pin levels as inputs. */
`timescale 1ns/10ps
module pcm_backplane #(
  parameter int FRAME_BITS = 96
) (
  output logic       pcm_bit_clk,
  output logic       frame_pulse,
  output logic       pcm_rx_in_a,
  input  wire logic  tx_line,
  input  wire logic  strobe_line,
  input  var  int    rx_start,
  input  wire logic [7:0] rx_byte,
  output logic [7:0] tx_byte,
  output int         tx_bits,
  output int         tx_first,
  output int         frame_cnt
);
  int         cnt = 0;
  int         k;
  int         bits_q = 0;
  int         first_q = 0;
  logic [7:0] shift_q = 8'h00;

  // short frame keeps the run brief, still in the slowest rate band
  initial begin
    pcm_bit_clk = 1'b0;
    frame_pulse = 1'b0;
    pcm_rx_in_a = 1'b0;
    frame_cnt = 0;
  end
  always #80 pcm_bit_clk = ~pcm_bit_clk;

  // new bit after each rising edge, steady over the falling edge
  always @(posedge pcm_bit_clk) begin
    cnt = (cnt == FRAME_BITS - 1) ? 0 : cnt + 1;
    k = cnt - rx_start;
    frame_pulse <= (cnt == FRAME_BITS - 1);
    pcm_rx_in_a <= (k >= 0 && k < 8) ? rx_byte[7 - k] : ~pcm_rx_in_a;
    if (cnt == 0) begin
      tx_byte <= shift_q;
      tx_bits <= bits_q;
      tx_first <= first_q;
      frame_cnt <= frame_cnt + 1;
      bits_q = 0;
    end
  end

  // the strobe enables the line driver, so take data only under it
  always @(negedge pcm_bit_clk) begin
    if (strobe_line === 1'b0) begin
      if (bits_q == 0) first_q = cnt;
      bits_q = bits_q + 1;
      shift_q = {shift_q[6:0], tx_line};
    end
  end
endmodule // pcm_backplane

/* File: tb/pcm_highway_port_tb_top.sv */
/* Self-checking bench for the PCM highway port: slot rows, overrun,
   power-down, pin reset, unmapped access. Assumes pcm_backplane. */
`timescale 1ns/10ps
`include "pcm_port_params.svh"
module pcm_highway_port_tb_top;
  import pcm_port_pkg::*;
  typedef struct {
    int ch, txs, txsh, rxs, rxsh;
    logic [7:0] txb, rxb;
  } row_t;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        mode_select_low = 1'b0;
  logic        mode_select_high = 1'b1;
  logic        frame_pulse, pcm_bit_clk, pcm_rx_in_a;
  logic        pcm_tx_out_a_o, pcm_tx_out_a_oe;
  logic        tx_slot_strobe_a_o, tx_slot_strobe_a_oe;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  rx_word_t    rx_word;
  logic        rx_word_valid;
  logic        rx_word_ready = 1'b0;
  wire logic   tx_line = pcm_tx_out_a_oe ? pcm_tx_out_a_o : 1'bz;
  // pull-up when released
  wire logic   strobe_line = tx_slot_strobe_a_oe ? tx_slot_strobe_a_o : 1'b1;
  int          rx_start = 0;
  logic [7:0]  rx_byte = 8'h00;
  logic [7:0]  tx_byte;
  int          tx_bits, tx_first, frame_cnt;
  int          miscompares = 0;
  int          check_count = 0;
  row_t        r;
  row_t        rows [3] = '{'{0, 0, 0, 0, 0, 8'hA5, 8'h3C},
    '{1, 10, 7, 5, 7, 8'h69, 8'h96}, '{3, 3, 5, 11, 0, 8'h81, 8'h7E}};

  pcm_highway_port dut (.*);
  pcm_backplane bp (.*);
  always #2 mclk = ~mclk;

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // entered just after a rising edge; holds until waitrequest is low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk((q & m) === e, "register read");
  endtask
  task automatic frames(input int n);
    int f;
    f = frame_cnt;
    while (frame_cnt < f + n) @(posedge mclk);
    // a quarter frame on: writes never cut or open a slot midway
    repeat (960) @(posedge mclk);
  endtask
  task automatic pop_chk(input rx_word_t e);
    chk(rx_word_valid === 1'b1 && rx_word === e, "received word");
    rx_word_ready <= 1'b1;
    @(posedge mclk);
    rx_word_ready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    chk(avs_waitrequest === 1'b1 && pcm_tx_out_a_oe === 1'b0, "reset");
    reset <= 1'b0;
    @(posedge mclk);
    rd_chk(`REG_CTRL, `CTRL_RESET, 32'hFFFF_FFFF);
    frames(2);
    rd_chk(`REG_STATUS, 32'h4, 32'h7);
    foreach (rows[i]) begin
      r = rows[i];
      rx_start <= r.rxsh + 8 * r.rxs;
      rx_byte <= r.rxb;
      rx_word_ready <= 1'b1;
      wr(`REG_CTRL, 32'(r.rxsh * 16 + r.txsh));
      wr(`REG_SLOT_BASE + 8'(4 * r.ch), 32'(32'h8080 + r.rxs * 256 + r.txs));
      wr(`REG_TXDATA_BASE + 8'(4 * r.ch), 32'(r.txb));
      frames(1);
      rx_word_ready <= 1'b0;
      frames(1);
      chk(tx_byte === r.txb && tx_bits == 8, "tx byte");
      chk(tx_first == r.txsh + 8 * r.txs, "tx slot");
      pop_chk({2'(r.ch), r.rxb});
      rd_chk(`REG_RXDATA_BASE + 8'(4 * r.ch), 32'(r.rxb), 32'hFF);
      wr(`REG_SLOT_BASE + 8'(4 * r.ch), 32'h0);
    end
    // four words into two entries: the third and fourth are dropped and flagged
    wr(`REG_CTRL, 32'h0);
    rx_start <= 32;
    rx_byte <= 8'hC3;
    wr(`REG_TXDATA_BASE + 8'h8, 32'h5A);
    wr(`REG_SLOT_BASE + 8'h8, 32'h8482);
    frames(4);
    wr(`REG_SLOT_BASE + 8'h8, 32'h0082);
    chk(tx_byte === 8'h5A && tx_first == 16, "tx slot 2");
    rd_chk(`REG_STATUS, 32'hC, 32'hF);
    pop_chk({2'd2, 8'hC3});
    pop_chk({2'd2, 8'hC3});
    chk(rx_word_valid === 1'b0, "buffer not empty");
    wr(`REG_STATUS, 32'h8);
    rd_chk(`REG_STATUS, 32'h4, 32'hF);
    wr(`REG_CTRL, 32'h400);
    frames(2);
    chk(tx_bits == 0, "powered-down slot driven");
    wr(`REG_CTRL, 32'h0);
    mode_select_high <= 1'b0;
    frames(2);
    chk(tx_bits == 0, "driven in pin reset");
    rd_chk(`REG_SLOT_BASE + 8'h8, 32'h0, 32'hFFFF_FFFF);
    mode_select_high <= 1'b1;
    wr(8'hFC, 32'hFFFF_FFFF);
    rd_chk(8'hFC, 32'h0, 32'hFFFF_FFFF);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(avs_waitrequest === 1'b1 && rx_word_valid === 1'b0, "reset");
    reset <= 1'b0;
    @(posedge mclk);
    rd_chk(`REG_CTRL, `CTRL_RESET, 32'hFFFF_FFFF);
    wrap_up();
  end

  // sixteen frames of 15.36 us plus ten quarter frames fit in this span
  initial begin
    #350us;
    miscompares = miscompares + 1;
    wrap_up();
  end
endmodule // pcm_highway_port_tb_top

bind pcm_highway_port pcm_highway_port_asserts chk_i (.*);
